// ==== include/dcp_pkg.sv ====
// constants for the channel one parameter readback block
// assumes one 100 MHz clock and a plain strobe register port
package dcp_pkg;

    // ************************************************************
    // bus geometry
    // ************************************************************
    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;

    // ************************************************************
    // register offsets, byte addresses
    // ************************************************************
    localparam logic [11:0] PARAM_HIGH_OFF  = 12'h3E4;
    localparam logic [11:0] VIEW_SELECT_OFF = 12'hF00;
    localparam logic [11:0] VIEW_VALUE_OFF  = 12'hF04;
    localparam logic [11:0] CFG_STATUS_OFF  = 12'hF08;
    localparam logic [11:0] READ_COUNT_OFF  = 12'hF0C;

    // ************************************************************
    // parameter word layout
    // ************************************************************
    localparam int DEPTH_LSB   = 28;
    localparam int BURST_LSB   = 16;
    localparam int FLOW_LSB    = 14;
    localparam int MBLK_BIT    = 11;
    localparam int LOCK_BIT    = 10;
    localparam int GATHER_BIT  = 9;
    localparam int SCATTER_BIT = 8;
    localparam int SRC_W_LSB   = 3;
    localparam int DST_W_LSB   = 0;
    localparam logic [31:0] RESERVED_MASK = 32'h8FF830C0;

    // ************************************************************
    // values after reset and default codes
    // ************************************************************
    localparam logic [31:0] PARAM_RESET      = 32'h00000000;
    localparam logic [2:0]  DEPTH_DEFAULT    = 3'h1;
    localparam logic [2:0]  BURST_DEFAULT    = 3'h1;
    localparam logic [1:0]  FLOW_DEFAULT     = 2'h0;
    localparam logic        FLAG_DEFAULT     = 1'h0;
    localparam logic [2:0]  WIDTH_DEFAULT    = 3'h0;
    localparam logic [3:0]  VIEW_SEL_RESET   = 4'h0;
    localparam logic [31:0] READ_COUNT_RESET = 32'h00000000;

    // ************************************************************
    // code limits and decode bases
    // ************************************************************
    localparam logic [2:0]  DEPTH_MAX_CODE = 3'h4;
    localparam logic [2:0]  SIZE_MAX_CODE  = 3'h6;
    localparam logic [31:0] DEPTH_BASE     = 32'h00000008;
    localparam logic [31:0] BURST_BASE     = 32'h00000004;
    localparam logic [31:0] WIDTH_BASE     = 32'h00000004;

    // ************************************************************
    // field table for the decoded view
    // ************************************************************
    localparam int FIELD_COUNT = 9;
    localparam logic [1:0] KIND_DEPTH = 2'h0;
    localparam logic [1:0] KIND_BURST = 2'h1;
    localparam logic [1:0] KIND_WIDTH = 2'h2;
    localparam logic [1:0] KIND_RAW   = 2'h3;
    localparam int FIELD_LSB [FIELD_COUNT] =
        '{28, 16, 14, 11, 10, 9, 8, 3, 0};
    localparam int FIELD_WID [FIELD_COUNT] =
        '{3, 3, 2, 1, 1, 1, 1, 3, 3};
    localparam logic [1:0] FIELD_KIND [FIELD_COUNT] =
        '{2'h0, 2'h1, 2'h3, 2'h3, 2'h3, 2'h3, 2'h3, 2'h2, 2'h2};

endpackage

// ==== hw/dcp_param_word.sv ====
// registered assembly of the channel one parameter word
// assumes codes are build-time constants from the parent
`timescale 1ns/1ns
module dcp_param_word (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rst_n,
    // field codes
    input  wire logic [2:0]  depth_code,
    input  wire logic [2:0]  burst_code,
    input  wire logic [1:0]  flow_code,
    input  wire logic        multiblock,
    input  wire logic        lock,
    input  wire logic        gather,
    input  wire logic        scatter,
    input  wire logic [2:0]  src_code,
    input  wire logic [2:0]  dst_code,
    // packed word
    output logic      [31:0] param_word,
    output logic             code_reserved
);

    logic [31:0] next_param_word;
    logic        next_code_reserved;

    // ************************************************************
    // packing
    // ************************************************************
    always_comb begin
        next_param_word = 32'h00000000;
        next_param_word[dcp_pkg::DEPTH_LSB +: 3] = depth_code;
        next_param_word[dcp_pkg::BURST_LSB +: 3] = burst_code;
        next_param_word[dcp_pkg::FLOW_LSB +: 2] = flow_code;
        next_param_word[dcp_pkg::MBLK_BIT] = multiblock;
        next_param_word[dcp_pkg::LOCK_BIT] = lock;
        next_param_word[dcp_pkg::GATHER_BIT] = gather;
        next_param_word[dcp_pkg::SCATTER_BIT] = scatter;
        next_param_word[dcp_pkg::SRC_W_LSB +: 3] = src_code;
        next_param_word[dcp_pkg::DST_W_LSB +: 3] = dst_code;
        next_param_word = next_param_word & ~dcp_pkg::RESERVED_MASK;
        next_code_reserved = (depth_code > dcp_pkg::DEPTH_MAX_CODE)
                          || (burst_code > dcp_pkg::SIZE_MAX_CODE)
                          || (src_code > dcp_pkg::SIZE_MAX_CODE)
                          || (dst_code > dcp_pkg::SIZE_MAX_CODE);
    end

    // ************************************************************
    // output register
    // ************************************************************
    // zero during reset
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            param_word    <= dcp_pkg::PARAM_RESET;
            code_reserved <= 1'b0;
        end else begin
            param_word    <= next_param_word;
            code_reserved <= next_code_reserved;
        end
    end

endmodule

// ==== hw/dcp_chan_one_param.sv ====
// channel one parameter readback register with decoded view
// assumes a one-cycle strobe register port on the 100 MHz clock
`timescale 1ns/1ns
// What this block does
// - read-only parameter word at 0x3E4, reset zero
// - bits 30:28 give buffer depth code
// - bits 18:16 give burst multiple code
// - bits 15:14 give flow control owner
// - bit 11 shows multiblock support
// - bit 10 shows lock support
// - bit 9 shows source gather support
// - bit 8 shows destination scatter support
// - bits 5:3 give fixed source width
// - bits 2:0 give fixed destination width
module dcp_chan_one_param #(
    parameter logic [2:0] BUFFER_DEPTH_CODE = dcp_pkg::DEPTH_DEFAULT,
    parameter logic [2:0] BURST_LIMIT_CODE  = dcp_pkg::BURST_DEFAULT,
    parameter logic [1:0] FLOW_OWNER_CODE   = dcp_pkg::FLOW_DEFAULT,
    parameter logic       MULTIBLOCK_EN     = dcp_pkg::FLAG_DEFAULT,
    parameter logic       LOCK_EN           = dcp_pkg::FLAG_DEFAULT,
    parameter logic       GATHER_EN         = dcp_pkg::FLAG_DEFAULT,
    parameter logic       SCATTER_EN        = dcp_pkg::FLAG_DEFAULT,
    parameter logic [2:0] SRC_WIDTH_CODE    = dcp_pkg::WIDTH_DEFAULT,
    parameter logic [2:0] DST_WIDTH_CODE    = dcp_pkg::WIDTH_DEFAULT
) (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rst_n,
    // register port
    input  wire logic [11:0] addr,
    input  wire logic [31:0] wr_data,
    input  wire logic        wr_en,
    input  wire logic        rd_en,
    output logic      [31:0] rd_data,
    // configuration health
    output logic             cfg_code_reserved,
    // parameter fields
    output logic      [2:0]  chan_one_buffer_depth,
    output logic      [2:0]  chan_one_burst_limit,
    output logic      [1:0]  chan_one_flow_owner,
    output logic             chan_one_multiblock_present,
    output logic             chan_one_lock_present,
    output logic             chan_one_gather_present,
    output logic             chan_one_scatter_present,
    output logic      [2:0]  chan_one_src_width_fixed,
    output logic      [2:0]  chan_one_dst_width_fixed
);

    // ************************************************************
    // declarations
    // ************************************************************
    logic [31:0] param_word;
    logic        code_reserved;
    logic [3:0]  view_select;
    logic [31:0] read_count;
    logic [31:0] view_value;
    logic [31:0] next_rd_data;
    logic [2:0]  field_code  [dcp_pkg::FIELD_COUNT];
    logic [31:0] field_value [dcp_pkg::FIELD_COUNT];
    logic        field_bad   [dcp_pkg::FIELD_COUNT];
    logic        sel_param;
    logic        sel_view_select;
    logic        sel_view_value;
    logic        sel_cfg_status;
    logic        sel_read_count;

    // ************************************************************
    // decode helpers
    // ************************************************************
    function automatic logic [31:0] decode_field(
        input logic [1:0] kind,
        input logic [2:0] code
    );
        logic [31:0] result;
        result = 32'h00000000;
        case (kind)
            dcp_pkg::KIND_DEPTH: begin
                if (code <= dcp_pkg::DEPTH_MAX_CODE) begin
                    result = dcp_pkg::DEPTH_BASE << code;
                end
            end
            dcp_pkg::KIND_BURST: begin
                // 4 to 256, code 7 none
                if (code <= dcp_pkg::SIZE_MAX_CODE) begin
                    result = dcp_pkg::BURST_BASE << code;
                end
            end
            dcp_pkg::KIND_WIDTH: begin
                if (code != 3'h0 && code <= dcp_pkg::SIZE_MAX_CODE) begin
                    result = dcp_pkg::WIDTH_BASE << code;
                end
            end
            default: begin
                result = {29'h0, code};
            end
        endcase
        return result;
    endfunction

    function automatic logic code_is_reserved(
        input logic [1:0] kind,
        input logic [2:0] code
    );
        logic bad;
        bad = 1'b0;
        case (kind)
            dcp_pkg::KIND_DEPTH: begin
                bad = code > dcp_pkg::DEPTH_MAX_CODE;
            end
            dcp_pkg::KIND_BURST,
            dcp_pkg::KIND_WIDTH: begin
                bad = code > dcp_pkg::SIZE_MAX_CODE;
            end
            default: begin
                bad = 1'b0;
            end
        endcase
        return bad;
    endfunction

    function automatic logic hit(
        input logic [11:0] a,
        input logic [11:0] off
    );
        return a == off;
    endfunction

    // ************************************************************
    // parameter word
    // ************************************************************
    dcp_param_word u_word (
        .clk           (clk),
        .rst_n         (rst_n),
        .depth_code    (BUFFER_DEPTH_CODE),
        .burst_code    (BURST_LIMIT_CODE),
        .flow_code     (FLOW_OWNER_CODE),
        .multiblock    (MULTIBLOCK_EN),
        .lock          (LOCK_EN),
        .gather        (GATHER_EN),
        .scatter       (SCATTER_EN),
        .src_code      (SRC_WIDTH_CODE),
        .dst_code      (DST_WIDTH_CODE),
        .param_word    (param_word),
        .code_reserved (code_reserved)
    );

    // ************************************************************
    // field outputs
    // ************************************************************
    // depth code out
    assign chan_one_buffer_depth =
        param_word[dcp_pkg::DEPTH_LSB +: 3];
    assign chan_one_burst_limit =
        param_word[dcp_pkg::BURST_LSB +: 3];
    assign chan_one_flow_owner =
        param_word[dcp_pkg::FLOW_LSB +: 2];
    assign chan_one_multiblock_present =
        param_word[dcp_pkg::MBLK_BIT];
    assign chan_one_lock_present =
        param_word[dcp_pkg::LOCK_BIT];
    assign chan_one_gather_present =
        param_word[dcp_pkg::GATHER_BIT];
    assign chan_one_scatter_present =
        param_word[dcp_pkg::SCATTER_BIT];
    assign chan_one_src_width_fixed =
        param_word[dcp_pkg::SRC_W_LSB +: 3];
    assign chan_one_dst_width_fixed =
        param_word[dcp_pkg::DST_W_LSB +: 3];
    assign cfg_code_reserved = code_reserved;

    // ************************************************************
    // per field decode
    // ************************************************************
    genvar gi;
    generate
        for (gi = 0; gi < dcp_pkg::FIELD_COUNT; gi++) begin : g_field
            localparam int          LSB  = dcp_pkg::FIELD_LSB[gi];
            localparam int          WID  = dcp_pkg::FIELD_WID[gi];
            localparam logic [1:0]  KIND = dcp_pkg::FIELD_KIND[gi];
            localparam logic [2:0]  MASK = 3'((1 << WID) - 1);
            logic [31:0] shifted;
            assign shifted = param_word >> LSB;
            assign field_code[gi]  = shifted[2:0] & MASK;
            assign field_value[gi] = decode_field(KIND, field_code[gi]);
            assign field_bad[gi]   = code_is_reserved(KIND,
                                                      field_code[gi]);
        end
    endgenerate

    // ************************************************************
    // decoded view of the selected field
    // ************************************************************
    always_comb begin
        view_value = 32'h00000000;
        for (int i = 0; i < dcp_pkg::FIELD_COUNT; i++) begin
            if (view_select == 4'(i)) begin
                view_value = {field_bad[i], field_value[i][30:0]};
            end
        end
    end

    // ************************************************************
    // address decode
    // ************************************************************
    // fixed offset
    assign sel_param       = hit(addr, dcp_pkg::PARAM_HIGH_OFF);
    assign sel_view_select = hit(addr, dcp_pkg::VIEW_SELECT_OFF);
    assign sel_view_value  = hit(addr, dcp_pkg::VIEW_VALUE_OFF);
    assign sel_cfg_status  = hit(addr, dcp_pkg::CFG_STATUS_OFF);
    assign sel_read_count  = hit(addr, dcp_pkg::READ_COUNT_OFF);

    // ************************************************************
    // writable registers
    // ************************************************************
    // only own registers take writes
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            view_select <= dcp_pkg::VIEW_SEL_RESET;
        end else if (wr_en && sel_view_select) begin
            view_select <= wr_data[3:0];
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            read_count <= dcp_pkg::READ_COUNT_RESET;
        end else if (rd_en && sel_param) begin
            if (read_count != 32'hFFFFFFFF) begin
                read_count <= read_count + 32'h00000001;
            end
        end else if (wr_en && sel_read_count) begin
            read_count <= dcp_pkg::READ_COUNT_RESET;
        end
    end

    // ************************************************************
    // read path
    // ************************************************************
    always_comb begin
        next_rd_data = 32'h00000000;
        if (rd_en) begin
            if (sel_param) begin
                next_rd_data = param_word;
            end else if (sel_view_select) begin
                next_rd_data = {28'h0000000, view_select};
            end else if (sel_view_value) begin
                next_rd_data = view_value;
            end else if (sel_cfg_status) begin
                next_rd_data = {31'h0, code_reserved};
            end else if (sel_read_count) begin
                next_rd_data = read_count;
            end
        end
    end

    // read data only in the cycle after the strobe
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rd_data <= 32'h00000000;
        end else begin
            rd_data <= next_rd_data;
        end
    end

endmodule

// ==== dv/dcp_chan_one_param_asserts.sv ====
// concurrent checks on the channel one parameter readback block
// assumes binding onto dcp_chan_one_param with matching parameters
`timescale 1ns/1ns
module dcp_chan_one_param_asserts #(
    parameter logic [2:0] BUFFER_DEPTH_CODE = dcp_pkg::DEPTH_DEFAULT,
    parameter logic [2:0] BURST_LIMIT_CODE  = dcp_pkg::BURST_DEFAULT,
    parameter logic [1:0] FLOW_OWNER_CODE   = dcp_pkg::FLOW_DEFAULT,
    parameter logic       MULTIBLOCK_EN     = dcp_pkg::FLAG_DEFAULT,
    parameter logic       LOCK_EN           = dcp_pkg::FLAG_DEFAULT,
    parameter logic       GATHER_EN         = dcp_pkg::FLAG_DEFAULT,
    parameter logic       SCATTER_EN        = dcp_pkg::FLAG_DEFAULT,
    parameter logic [2:0] SRC_WIDTH_CODE    = dcp_pkg::WIDTH_DEFAULT,
    parameter logic [2:0] DST_WIDTH_CODE    = dcp_pkg::WIDTH_DEFAULT
) (
    // clock and reset
    input wire logic        clk,
    input wire logic        rst_n,
    // register port
    input wire logic [11:0] addr,
    input wire logic [31:0] wr_data,
    input wire logic        wr_en,
    input wire logic        rd_en,
    input wire logic [31:0] rd_data,
    // health and fields
    input wire logic        cfg_code_reserved,
    input wire logic [2:0]  chan_one_buffer_depth,
    input wire logic [2:0]  chan_one_burst_limit,
    input wire logic [1:0]  chan_one_flow_owner,
    input wire logic        chan_one_multiblock_present,
    input wire logic        chan_one_lock_present,
    input wire logic        chan_one_gather_present,
    input wire logic        chan_one_scatter_present,
    input wire logic [2:0]  chan_one_src_width_fixed,
    input wire logic [2:0]  chan_one_dst_width_fixed
);
    // ************************************************************
    // expected word and sequences
    // ************************************************************
    localparam logic [31:0] EXP_WORD = {1'b0, BUFFER_DEPTH_CODE, 9'h000,
        BURST_LIMIT_CODE, FLOW_OWNER_CODE, 2'h0, MULTIBLOCK_EN, LOCK_EN,
        GATHER_EN, SCATTER_EN, 2'h0, SRC_WIDTH_CODE, DST_WIDTH_CODE};
    localparam logic CFG_BAD = (BUFFER_DEPTH_CODE > 3'h4) ||
        (BURST_LIMIT_CODE == 3'h7) || (SRC_WIDTH_CODE == 3'h7) ||
        (DST_WIDTH_CODE == 3'h7);

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    sequence s_word_rd;
        rd_en && addr == dcp_pkg::PARAM_HIGH_OFF;
    endsequence
    sequence s_word_wr;
        wr_en && addr == dcp_pkg::PARAM_HIGH_OFF;
    endsequence

    // ************************************************************
    // assertions
    // ************************************************************
    a_word_read: assert property (s_word_rd |=> rd_data == EXP_WORD)
        else $error("parameter word read wrong");
    a_reserved_zero: assert property (s_word_rd |=>
        (rd_data & dcp_pkg::RESERVED_MASK) == 32'h0)
        else $error("reserved bits not zero");
    a_write_ignored: assert property (s_word_wr ##1 s_word_rd |=>
        rd_data == EXP_WORD) else $error("write changed the word");
    a_rd_idle_zero: assert property (!rd_en |=> rd_data == 32'h0)
        else $error("read data without a read");
    a_depth_field: assert property ($past(rst_n) |->
        chan_one_buffer_depth == BUFFER_DEPTH_CODE)
        else $error("depth field wrong");
    a_burst_field: assert property ($past(rst_n) |->
        chan_one_burst_limit == BURST_LIMIT_CODE)
        else $error("burst field wrong");
    a_flow_field: assert property ($past(rst_n) |->
        chan_one_flow_owner == FLOW_OWNER_CODE)
        else $error("flow field wrong");
    a_flag_fields: assert property ($past(rst_n) |->
        {chan_one_multiblock_present, chan_one_lock_present,
         chan_one_gather_present, chan_one_scatter_present} ==
        {MULTIBLOCK_EN, LOCK_EN, GATHER_EN, SCATTER_EN})
        else $error("feature flags wrong");
    a_width_fields: assert property ($past(rst_n) |->
        {chan_one_src_width_fixed, chan_one_dst_width_fixed} ==
        {SRC_WIDTH_CODE, DST_WIDTH_CODE}) else $error("width fields wrong");
    a_cfg_health: assert property ($past(rst_n) |->
        cfg_code_reserved == CFG_BAD) else $error("health flag wrong");
endmodule

// ==== dv/tb.sv ====
// self-checking bench for the channel one parameter readback block
// assumes the strobe register port and a 100 MHz clock
`timescale 1ns/1ns
module tb;
    // ************************************************************
    // configuration under test and signals
    // ************************************************************
    localparam logic [2:0] DEP = 3'h4;
    localparam logic [2:0] BUR = 3'h6;
    localparam logic [1:0] FLO = 2'h2;
    localparam logic [2:0] SRC = 3'h5;
    localparam logic [2:0] DST = 3'h3;
    localparam logic [31:0] WORD = {1'b0, DEP, 9'h000, BUR, FLO, 2'h0,
        1'b1, 1'b0, 1'b1, 1'b0, 2'h0, SRC, DST};
    logic        clk;
    logic        rst_n;
    logic [11:0] addr;
    logic [31:0] wr_data;
    logic        wr_en;
    logic        rd_en;
    logic [31:0] rd_data;
    logic        cfg_bad;
    logic [31:0] rd_data2;
    logic        cfg_bad2;
    logic [2:0]  depth, burst, srcw, dstw;
    logic [1:0]  flow;
    logic        mblk, lck, gat, sca;
    logic [31:0] view_exp [10];
    int          n_mismatch;
    int          tests_run;

    dcp_chan_one_param #(.BUFFER_DEPTH_CODE(DEP), .BURST_LIMIT_CODE(BUR),
        .FLOW_OWNER_CODE(FLO), .MULTIBLOCK_EN(1'b1), .LOCK_EN(1'b0),
        .GATHER_EN(1'b1), .SCATTER_EN(1'b0), .SRC_WIDTH_CODE(SRC),
        .DST_WIDTH_CODE(DST)) i_dcp_chan_one_param (
        .clk(clk), .rst_n(rst_n), .addr(addr), .wr_data(wr_data),
        .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data),
        .cfg_code_reserved(cfg_bad), .chan_one_buffer_depth(depth),
        .chan_one_burst_limit(burst), .chan_one_flow_owner(flow),
        .chan_one_multiblock_present(mblk), .chan_one_lock_present(lck),
        .chan_one_gather_present(gat), .chan_one_scatter_present(sca),
        .chan_one_src_width_fixed(srcw), .chan_one_dst_width_fixed(dstw));

    // second build with reserved codes, same register port
    dcp_chan_one_param #(.BUFFER_DEPTH_CODE(3'h5), .BURST_LIMIT_CODE(3'h7),
        .SRC_WIDTH_CODE(3'h7)) i_dcp_chan_one_param_rsv (
        .clk(clk), .rst_n(rst_n), .addr(addr), .wr_data(wr_data),
        .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data2),
        .cfg_code_reserved(cfg_bad2), .chan_one_buffer_depth(),
        .chan_one_burst_limit(), .chan_one_flow_owner(),
        .chan_one_multiblock_present(), .chan_one_lock_present(),
        .chan_one_gather_present(), .chan_one_scatter_present(),
        .chan_one_src_width_fixed(), .chan_one_dst_width_fixed());

    // ************************************************************
    // clock, tasks
    // ************************************************************
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("ERROR t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic drive(input logic w, input logic r, input logic [11:0] a,
                         input logic [31:0] d);
        @(posedge clk);
        wr_en   <= w;
        rd_en   <= r;
        addr    <= a;
        wr_data <= d;
    endtask

    task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
        drive(1'b0, 1'b1, a, 32'h00000000);
        drive(1'b0, 1'b0, a, 32'h00000000);
        #1 check(rd_data, exp);
    endtask

    task automatic summarize();
        $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // ************************************************************
    // watchdog and tests
    // ************************************************************
    initial begin
        repeat (5000) @(posedge clk);
        n_mismatch++;
        summarize();
    end

    initial begin
        rst_n = 1'b0; addr = 12'h000; wr_data = 32'h00000000;
        wr_en = 1'b0; rd_en = 1'b0; n_mismatch = 0; tests_run = 0;
        view_exp = '{32'h8 << DEP, 32'h4 << BUR, 32'(FLO), 32'h1, 32'h0,
                     32'h1, 32'h0, 32'h4 << SRC, 32'h4 << DST, 32'h0};
        repeat (11) @(posedge clk);
        #1 check(32'({cfg_bad, cfg_bad2, depth, burst, flow, mblk, lck, gat,
                  sca, srcw, dstw}), 32'h00000000);
        check(rd_data | rd_data2, 32'h00000000);
        @(posedge clk);
        rst_n <= 1'b1;
        $display("done: reset values");
        rd_chk(dcp_pkg::PARAM_HIGH_OFF, WORD);
        check(32'({depth, burst, flow, mblk, lck, gat, sca, srcw, dstw}),
              32'({DEP, BUR, FLO, 4'hA, SRC, DST}));
        check(rd_data & dcp_pkg::RESERVED_MASK, 32'h00000000);
        check(rd_data2, 32'h50070038);
        check(32'(cfg_bad2), 32'h00000001);
        $display("done: word readback");
        drive(1'b1, 1'b0, dcp_pkg::PARAM_HIGH_OFF, 32'hFFFFFFFF);
        drive(1'b0, 1'b1, dcp_pkg::PARAM_HIGH_OFF, 32'h00000000);
        drive(1'b0, 1'b1, dcp_pkg::PARAM_HIGH_OFF, 32'h00000000);
        #1 check(rd_data, WORD);
        drive(1'b0, 1'b0, dcp_pkg::PARAM_HIGH_OFF, 32'h00000000);
        #1 check(rd_data, WORD);
        drive(1'b0, 1'b0, dcp_pkg::PARAM_HIGH_OFF, 32'h00000000);
        #1 check(rd_data, 32'h00000000);
        rd_chk(dcp_pkg::READ_COUNT_OFF, 32'h00000003);
        drive(1'b1, 1'b0, dcp_pkg::READ_COUNT_OFF, 32'h12345678);
        rd_chk(dcp_pkg::READ_COUNT_OFF, 32'h00000000);
        $display("done: write ignored");
        rd_chk(12'h3E0, 32'h00000000);
        rd_chk(12'h3E8, 32'h00000000);
        drive(1'b1, 1'b0, dcp_pkg::CFG_STATUS_OFF, 32'hFFFFFFFF);
        rd_chk(dcp_pkg::CFG_STATUS_OFF, 32'h00000000);
        check(rd_data2, 32'h00000001);
        $display("done: unmapped and status");
        for (int i = 0; i < 10; i++) begin
            drive(1'b1, 1'b0, dcp_pkg::VIEW_SELECT_OFF, 32'(i));
            rd_chk(dcp_pkg::VIEW_SELECT_OFF, 32'(i));
            rd_chk(dcp_pkg::VIEW_VALUE_OFF, view_exp[i]);
            check(rd_data2, (i == 0 || i == 1 || i == 7) ?
                  32'h80000000 : 32'h00000000);
        end
        $display("done: decoded view");
        summarize();
    end
endmodule

bind dcp_chan_one_param dcp_chan_one_param_asserts #(
    .BUFFER_DEPTH_CODE(BUFFER_DEPTH_CODE), .BURST_LIMIT_CODE(BURST_LIMIT_CODE),
    .FLOW_OWNER_CODE(FLOW_OWNER_CODE), .MULTIBLOCK_EN(MULTIBLOCK_EN),
    .LOCK_EN(LOCK_EN), .GATHER_EN(GATHER_EN), .SCATTER_EN(SCATTER_EN),
    .SRC_WIDTH_CODE(SRC_WIDTH_CODE), .DST_WIDTH_CODE(DST_WIDTH_CODE)
) i_dcp_chan_one_param_asserts (
    .clk(clk), .rst_n(rst_n), .addr(addr), .wr_data(wr_data),
    .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data),
    .cfg_code_reserved(cfg_code_reserved),
    .chan_one_buffer_depth(chan_one_buffer_depth),
    .chan_one_burst_limit(chan_one_burst_limit),
    .chan_one_flow_owner(chan_one_flow_owner),
    .chan_one_multiblock_present(chan_one_multiblock_present),
    .chan_one_lock_present(chan_one_lock_present),
    .chan_one_gather_present(chan_one_gather_present),
    .chan_one_scatter_present(chan_one_scatter_present),
    .chan_one_src_width_fixed(chan_one_src_width_fixed),
    .chan_one_dst_width_fixed(chan_one_dst_width_fixed));
